// ---- core/auto_wake_sleep_control.sv ----
// Auto wake and sleep controller with its register file
module auto_wake_sleep_control
  import awsc_pkg::*;
#(
  parameter int BASE_CYCLES = awsc_pkg::BASE_TICK_CYCLES
) (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register access from the serial interface
  input awsc_pkg::awsc_reg_req_s regReq,
  output logic [7:0] regRdataFf,
  // Detection function events
  input awsc_pkg::awsc_events_s detectEvents,
  // Rate and mode outputs
  output logic [2:0] outputSampleRateFf,
  output logic sampleTickFf,
  output logic [3:0] functionEnableFf,
  output awsc_pkg::awsc_mode_e modeFf,
  output logic sleepWakeEventFf
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] durationFf, nxt_duration;
  logic [2:0] wakeRateFf, nxt_wakeRate;
  logic [1:0] sleepRateFf, nxt_sleepRate;
  logic activeFf, nxt_active;
  logic autoSleepFf, nxt_autoSleep;
  logic [3:0] wakeSrcFf, nxt_wakeSrc;
  logic [3:0] nxt_funcEn;
  logic sleepIenFf, nxt_sleepIen;
  logic [7:0] nxt_rdata;
  logic durationWrite;

  always_comb begin
    nxt_duration = durationFf;
    nxt_wakeRate = wakeRateFf;
    nxt_sleepRate = sleepRateFf;
    nxt_active = activeFf;
    nxt_autoSleep = autoSleepFf;
    nxt_wakeSrc = wakeSrcFf;
    nxt_funcEn = functionEnableFf;
    nxt_sleepIen = sleepIenFf;
    nxt_rdata = 8'h00;
    durationWrite = 1'b0;
    if (regReq.wr) begin
      unique case (regReq.addr)
        OFS_INACT_DURATION: begin
          nxt_duration = regReq.wdata;
          durationWrite = 1'b1;
        end
        OFS_SYSTEM_CONTROL_ONE: begin
          nxt_active = regReq.wdata[POS_ACTIVE];
          // Rates change only while activeFf is clear
          if (!activeFf) begin
            nxt_wakeRate = regReq.wdata[POS_WAKE_RATE_LO +: 3];
            nxt_sleepRate = regReq.wdata[POS_SLEEP_RATE_LO +: 2];
          end
        end
        OFS_SYSTEM_CONTROL_TWO:
          nxt_autoSleep = regReq.wdata[POS_AUTO_SLEEP_ENABLE];
        OFS_WAKE_SOURCE_CONTROL:
          nxt_wakeSrc = regReq.wdata[POS_SRC_FFMT +: 4];
        OFS_INTERRUPT_ENABLE_CONTROL: begin
          nxt_funcEn = regReq.wdata[POS_IEN_FFMT +: 4];
          nxt_sleepIen = regReq.wdata[POS_IEN_SLEEP_WAKE];
        end
        default: begin
        end
      endcase
    end
    if (regReq.rd) begin
      unique case (regReq.addr)
        OFS_SYSTEM_MODE:
          nxt_rdata = {6'h00, modeFf};
        OFS_INACT_DURATION:
          nxt_rdata = durationFf;
        OFS_SYSTEM_CONTROL_ONE:
          nxt_rdata = {sleepRateFf, wakeRateFf, 2'b00, activeFf};
        OFS_SYSTEM_CONTROL_TWO:
          nxt_rdata = {5'h00, autoSleepFf, 2'b00};
        OFS_WAKE_SOURCE_CONTROL:
          nxt_rdata = {1'b0, wakeSrcFf, 3'b000};
        OFS_INTERRUPT_ENABLE_CONTROL:
          nxt_rdata = {sleepIenFf, 1'b0, functionEnableFf, 2'b00};
        default:
          nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      durationFf <= RST_INACT_DURATION;
      wakeRateFf <= RST_WAKE_RATE;
      sleepRateFf <= RST_SLEEP_RATE;
      activeFf <= RST_ACTIVE;
      autoSleepFf <= RST_AUTO_SLEEP_ENABLE;
      wakeSrcFf <= RST_WAKE_SOURCE;
      functionEnableFf <= RST_FUNC_ENABLE;
      sleepIenFf <= RST_SLEEP_WAKE_IEN;
      regRdataFf <= 8'h00;
    end else if (ce) begin
      durationFf <= nxt_duration;
      wakeRateFf <= nxt_wakeRate;
      sleepRateFf <= nxt_sleepRate;
      activeFf <= nxt_active;
      autoSleepFf <= nxt_autoSleep;
      wakeSrcFf <= nxt_wakeSrc;
      functionEnableFf <= nxt_funcEn;
      sleepIenFf <= nxt_sleepIen;
      regRdataFf <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Base tick of 1.25 ms
  // ----------------------------------------------------------------
  logic baseTick;

  awsc_tick_div #(
    .CYCLES(BASE_CYCLES)
  ) u_base_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .tickFf(baseTick)
  );

  // ----------------------------------------------------------------
  // Mode, idle timer and sample rate
  // ----------------------------------------------------------------
  awsc_mode_e nxt_mode;
  logic [9:0] subCountFf, nxt_subCount;
  logic [7:0] stepCountFf, nxt_stepCount;
  logic [9:0] rateCountFf, nxt_rateCount;
  logic [2:0] nxt_rateCode;
  logic [9:0] ratio;
  logic [9:0] stepLen;
  logic nxt_sampleTick;
  logic nxt_event;
  logic [3:0] eventVec;
  logic keepAwake;
  logic wakeHit;
  logic idleDone;

  always_comb begin
    nxt_mode = modeFf;
    nxt_subCount = subCountFf;
    nxt_stepCount = stepCountFf;
    nxt_rateCount = rateCountFf;
    nxt_sampleTick = 1'b0;
    nxt_event = 1'b0;
    eventVec = detectEvents;
    keepAwake = |(eventVec & functionEnableFf);
    wakeHit = |(eventVec & functionEnableFf & wakeSrcFf);
    idleDone = (stepCountFf >= durationFf);
    stepLen = (wakeRateFf == RATE_1P56) ? STEP_LONG_TICKS : STEP_SHORT_TICKS;
    unique case (modeFf)
      MODE_STANDBY: begin
        if (activeFf) begin
          nxt_mode = MODE_WAKE;
        end
      end
      MODE_WAKE: begin
        if (!activeFf) begin
          nxt_mode = MODE_STANDBY;
        end else if (autoSleepFf && idleDone && !keepAwake) begin
          nxt_mode = MODE_SLEEP;
          nxt_event = sleepIenFf;
        end
      end
      MODE_SLEEP: begin
        if (!activeFf) begin
          nxt_mode = MODE_STANDBY;
        end else if (wakeHit || !autoSleepFf) begin
          nxt_mode = MODE_WAKE;
          nxt_event = sleepIenFf;
        end
      end
      default: nxt_mode = MODE_STANDBY;
    endcase
    if (modeFf != MODE_WAKE || keepAwake || durationWrite) begin
      nxt_subCount = 10'h000;
      nxt_stepCount = 8'h00;
    end else if (baseTick) begin
      if (subCountFf == stepLen - 10'h001) begin
        nxt_subCount = 10'h000;
        if (stepCountFf != 8'hFF) begin
          nxt_stepCount = stepCountFf + 8'h01;
        end
      end else begin
        nxt_subCount = subCountFf + 10'h001;
      end
    end
    unique case (sleepRateFf)
      2'b00: nxt_rateCode = SLEEP_50;
      2'b01: nxt_rateCode = SLEEP_12P5;
      2'b10: nxt_rateCode = SLEEP_6P25;
      2'b11: nxt_rateCode = SLEEP_1P56;
    endcase
    if (nxt_mode != MODE_SLEEP) begin
      nxt_rateCode = wakeRateFf;
    end
    unique case (outputSampleRateFf)
      3'h0: ratio = RATIO_800;
      3'h1: ratio = RATIO_400;
      3'h2: ratio = RATIO_200;
      3'h3: ratio = RATIO_100;
      3'h4: ratio = RATIO_50;
      3'h5: ratio = RATIO_12P5;
      3'h6: ratio = RATIO_6P25;
      3'h7: ratio = RATIO_1P56;
    endcase
    if (modeFf == MODE_STANDBY || nxt_rateCode != outputSampleRateFf) begin
      nxt_rateCount = 10'h000;
    end else if (baseTick) begin
      if (rateCountFf >= ratio - 10'h001) begin
        nxt_rateCount = 10'h000;
        nxt_sampleTick = 1'b1;
      end else begin
        nxt_rateCount = rateCountFf + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modeFf <= MODE_STANDBY;
      subCountFf <= 10'h000;
      stepCountFf <= 8'h00;
      rateCountFf <= 10'h000;
      outputSampleRateFf <= RST_WAKE_RATE;
      sampleTickFf <= 1'b0;
      sleepWakeEventFf <= 1'b0;
    end else if (ce) begin
      modeFf <= nxt_mode;
      subCountFf <= nxt_subCount;
      stepCountFf <= nxt_stepCount;
      rateCountFf <= nxt_rateCount;
      outputSampleRateFf <= nxt_rateCode;
      sampleTickFf <= nxt_sampleTick;
      sleepWakeEventFf <= nxt_event;
    end
  end

endmodule : auto_wake_sleep_control

// ---- core/awsc_pkg.sv ----
// Package of constants and types for the auto wake and sleep controller
package awsc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SYSTEM_MODE = 8'h0B;
  localparam logic [7:0] OFS_INACT_DURATION = 8'h29;
  localparam logic [7:0] OFS_SYSTEM_CONTROL_ONE = 8'h2A;
  localparam logic [7:0] OFS_SYSTEM_CONTROL_TWO = 8'h2B;
  localparam logic [7:0] OFS_WAKE_SOURCE_CONTROL = 8'h2C;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE_CONTROL = 8'h2D;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_ACTIVE = 0;
  localparam int POS_WAKE_RATE_LO = 3;
  localparam int POS_SLEEP_RATE_LO = 6;
  localparam int POS_AUTO_SLEEP_ENABLE = 2;
  localparam int POS_SRC_FFMT = 3;
  localparam int POS_IEN_FFMT = 2;
  localparam int POS_IEN_SLEEP_WAKE = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INACT_DURATION = 8'h00;
  localparam logic [2:0] RST_WAKE_RATE = 3'h0;
  localparam logic [1:0] RST_SLEEP_RATE = 2'h0;
  localparam logic RST_ACTIVE = 1'b0;
  localparam logic RST_AUTO_SLEEP_ENABLE = 1'b0;
  localparam logic [3:0] RST_WAKE_SOURCE = 4'h0;
  localparam logic [3:0] RST_FUNC_ENABLE = 4'h0;
  localparam logic RST_SLEEP_WAKE_IEN = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int BASE_TICK_NS = 1_250_000;
  localparam int BASE_TICK_CYCLES = (BASE_TICK_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int STEP_SHORT_MS = 320;
  localparam int STEP_LONG_MS = 640;
  localparam logic [9:0] STEP_SHORT_TICKS =
    10'(STEP_SHORT_MS * 1_000_000 / BASE_TICK_NS);
  localparam logic [9:0] STEP_LONG_TICKS =
    10'(STEP_LONG_MS * 1_000_000 / BASE_TICK_NS);

  // Rate codes and their periods in base ticks
  localparam logic [2:0] RATE_1P56 = 3'h7;
  localparam logic [9:0] RATIO_800 = 10'h001;
  localparam logic [9:0] RATIO_400 = 10'h002;
  localparam logic [9:0] RATIO_200 = 10'h004;
  localparam logic [9:0] RATIO_100 = 10'h008;
  localparam logic [9:0] RATIO_50 = 10'h010;
  localparam logic [9:0] RATIO_12P5 = 10'h040;
  localparam logic [9:0] RATIO_6P25 = 10'h080;
  localparam logic [9:0] RATIO_1P56 = 10'h200;

  // Sleep rate code to common rate code
  localparam logic [2:0] SLEEP_50 = 3'h4;
  localparam logic [2:0] SLEEP_12P5 = 3'h5;
  localparam logic [2:0] SLEEP_6P25 = 3'h6;
  localparam logic [2:0] SLEEP_1P56 = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_WAKE = 2'b01,
    MODE_SLEEP = 2'b10
  } awsc_mode_e;

  typedef struct packed {
    logic transient;
    logic orientation;
    logic tap;
    logic freefallMotion;
  } awsc_events_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } awsc_reg_req_s;

endpackage : awsc_pkg

// ---- core/awsc_tick_div.sv ----
// Divider that makes a one-cycle tick every CYCLES clocks
module awsc_tick_div #(
  parameter int CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Tick
  output logic tickFf
);

  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] countFf;
  logic [W-1:0] nxt_count;
  logic nxt_tick;

  always_comb begin
    nxt_count = countFf;
    nxt_tick = 1'b0;
    if (countFf == LAST) begin
      nxt_count = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_count = countFf + W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      countFf <= '0;
      tickFf <= 1'b0;
    end else if (ce) begin
      countFf <= nxt_count;
      tickFf <= nxt_tick;
    end
  end

endmodule : awsc_tick_div

// ---- tb/auto_wake_sleep_control_bench.sv ----
// Testbench of the auto wake and sleep controller
module auto_wake_sleep_control_bench
  import awsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 4;
  logic clk_sys, rst_n, ce, rdSeen, sampleTickFf, sleepWakeEventFf;
  awsc_reg_req_s regReq;
  awsc_events_s detectEvents;
  awsc_mode_e modeFf;
  logic [7:0] regRdataFf, expV, randV;
  logic [2:0] outputSampleRateFf;
  logic [3:0] functionEnableFf;
  logic [7:0] expQ[$];
  int failCount = 0, checked = 0, cycles = 0, n, seed;
  int tickCount = 0, evCount = 0;

  awsc_host_model u_host (.clk_sys(clk_sys), .regReq(regReq));
  auto_wake_sleep_control #(.BASE_CYCLES(BASE)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .regReq(regReq),
    .regRdataFf(regRdataFf), .detectEvents(detectEvents),
    .outputSampleRateFf(outputSampleRateFf), .sampleTickFf(sampleTickFf),
    .functionEnableFf(functionEnableFf), .modeFf(modeFf),
    .sleepWakeEventFf(sleepWakeEventFf));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'b1, 1'b0, a, d);
    u_host.idle();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    u_host.access(1'b0, 1'b1, a, 8'h00);
    u_host.idle();
  endtask : rd
  task automatic wait_mode(input awsc_mode_e m);
    n = 0;
    while (modeFf !== m && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 9000) begin
      chk(32'(modeFf), 32'(m));
    end
  endtask : wait_mode
  task automatic pulse(input logic [3:0] e);
    @(negedge clk_sys);
    detectEvents = e;
    @(negedge clk_sys);
    detectEvents = '0;
  endtask : pulse
  // --------------------------------
  // Read checker and timeout
  // --------------------------------
  always @(posedge clk_sys) begin
    if (rdSeen && expQ.size() > 0) begin
      expV = expQ.pop_front();
      chk(32'(regRdataFf), 32'(expV));
    end
    rdSeen <= regReq.rd;
    tickCount <= tickCount + int'(sampleTickFf);
    evCount <= evCount + int'(sleepWakeEventFf);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      summarize();
    end
  end
  // --------------------------------
  // Scenarios
  // --------------------------------
  initial begin
    seed = 47872;
    ce = 1'b1;
    rst_n = 1'b0;
    detectEvents = '0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(OFS_INACT_DURATION, 8'h00);
    rd(OFS_SYSTEM_CONTROL_ONE, 8'h00);
    rd(8'h30, 8'h00);
    randV = 8'($random(seed));
    expQ.push_back(randV);
    u_host.access(1'b1, 1'b0, OFS_INACT_DURATION, randV);
    u_host.access(1'b0, 1'b1, OFS_INACT_DURATION, 8'h00);
    u_host.idle();
    wr(OFS_INTERRUPT_ENABLE_CONTROL, 8'hBC);
    wr(OFS_WAKE_SOURCE_CONTROL, 8'h78);
    wr(OFS_SYSTEM_CONTROL_TWO, 8'h04);
    wr(OFS_INACT_DURATION, 8'h01);
    wr(OFS_SYSTEM_CONTROL_ONE, 8'h41);
    wait_mode(MODE_SLEEP);
    chk(32'(n inside {[1020:1100]}), 32'h1);
    chk(32'(outputSampleRateFf), 32'(SLEEP_12P5));
    for (int i = 0; i < 4; i++) begin
      pulse(4'(1 << i));
      wait_mode(MODE_WAKE);
      chk(32'(n < 4), 32'h1);
      repeat (300) @(negedge clk_sys);
      n = tickCount;
      repeat (300) @(negedge clk_sys);
      chk(32'(tickCount - n), 32'(300 / BASE));
      pulse(4'($random(seed)) | 4'h1);
      wait_mode(MODE_SLEEP);
      chk(32'(n inside {[1020:1100]}), 32'h1);
    end
    wr(OFS_WAKE_SOURCE_CONTROL, 8'h00);
    pulse(4'hF);
    repeat (20) @(negedge clk_sys);
    rd(OFS_SYSTEM_MODE, 8'h02);
    chk(32'(functionEnableFf), 32'h0000_000F);
    wr(OFS_SYSTEM_CONTROL_TWO, 8'h00);
    wait_mode(MODE_WAKE);
    repeat (2500) @(negedge clk_sys);
    rd(OFS_SYSTEM_MODE, 8'h01);
    wr(OFS_SYSTEM_CONTROL_ONE, 8'h00);
    wait_mode(MODE_STANDBY);
    wr(OFS_SYSTEM_CONTROL_ONE, 8'hF9);
    wr(OFS_SYSTEM_CONTROL_TWO, 8'h04);
    wait_mode(MODE_SLEEP);
    chk(32'(n inside {[2040:2120]}), 32'h1);
    rd(OFS_SYSTEM_CONTROL_ONE, 8'hF9);
    wr(OFS_INACT_DURATION, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_SYSTEM_CONTROL_ONE, 8'h00);
      wait_mode(MODE_STANDBY);
      wr(OFS_SYSTEM_CONTROL_ONE, {k[1:0], k[2:0], 3'b001});
      wait_mode(MODE_SLEEP);
      chk(32'(outputSampleRateFf), {29'h0, 1'b1, k[1:0]});
    end
    wr(OFS_SYSTEM_CONTROL_ONE, 8'h00);
    wait_mode(MODE_STANDBY);
    rd(OFS_SYSTEM_MODE, 8'h00);
    chk(32'(evCount), 32'h0000_0013);
    repeat (3) @(negedge clk_sys);
    summarize();
  end
endmodule : auto_wake_sleep_control_bench

// ---- tb/awsc_host_model.sv ----
// Host model that issues register reads and writes
module awsc_host_model
  import awsc_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register requests
  output awsc_pkg::awsc_reg_req_s regReq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial regReq = '0;
  // --------------------------------
  // Bus cycles
  // --------------------------------
  task automatic access(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge clk_sys);
    regReq = '{wr: w, rd: r, addr: a, wdata: d};
  endtask : access
  task automatic idle();
    @(negedge clk_sys);
    regReq = '0;
  endtask : idle
endmodule : awsc_host_model

// ---- tb/awsc_monitor.sv ----
// Checker of the auto wake and sleep controller ports
module awsc_monitor
  import awsc_pkg::*;
#(
  parameter int BASE_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input awsc_pkg::awsc_reg_req_s regReq,
  input wire logic [7:0] regRdataFf,
  // Events and status
  input awsc_pkg::awsc_events_s detectEvents,
  input wire logic [2:0] outputSampleRateFf,
  input wire logic sampleTickFf,
  input wire logic [3:0] functionEnableFf,
  input awsc_pkg::awsc_mode_e modeFf,
  input wire logic sleepWakeEventFf
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] durFf;
  logic actFf;
  logic [3:0] srcFf;
  logic [3:0] enFf;
  logic [2:0] wakeFf;
  logic [1:0] slpFf;
  logic aslpFf;
  logic ienFf;
  int idleFf;
  int minIdle;
  logic hit;
  logic wake;
  logic wrDur;
  logic rdDur;
  assign hit = |(detectEvents & functionEnableFf);
  assign wake = |(detectEvents & functionEnableFf & srcFf);
  assign wrDur = ce && regReq.wr && regReq.addr == OFS_INACT_DURATION;
  assign rdDur = ce && regReq.rd && !regReq.wr
                 && regReq.addr == OFS_INACT_DURATION;
  assign minIdle = BASE_CYCLES
                   * (int'(durFf) * (wakeFf == RATE_1P56 ? 512 : 256) - 1);
  // --------------------------------
  // Register shadows and idle count
  // --------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      durFf <= '0;
      srcFf <= '0;
      enFf <= '0;
      wakeFf <= '0;
      slpFf <= '0;
      aslpFf <= 1'b0;
      ienFf <= 1'b0;
      actFf <= 1'b0;
      idleFf <= 0;
    end else if (ce) begin
      if (regReq.wr) begin
        case (regReq.addr)
          OFS_INACT_DURATION: durFf <= regReq.wdata;
          OFS_SYSTEM_CONTROL_TWO: aslpFf <= regReq.wdata[2];
          OFS_WAKE_SOURCE_CONTROL: srcFf <= regReq.wdata[6:3];
          OFS_INTERRUPT_ENABLE_CONTROL: begin
            ienFf <= regReq.wdata[7];
            enFf <= regReq.wdata[5:2];
          end
          OFS_SYSTEM_CONTROL_ONE: begin
            actFf <= regReq.wdata[0];
            if (!actFf) begin
              slpFf <= regReq.wdata[7:6];
              wakeFf <= regReq.wdata[5:3];
            end
          end
          default: ;
        endcase
      end
      idleFf <= (modeFf != MODE_WAKE || hit || wrDur) ? 0 : idleFf + 1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // --------------------------------
  // Assertions and cover points
  // --------------------------------
  rdata_idle_a: assert property (ce && !regReq.rd |=>
    regRdataFf == 8'h00) else $error("read data not idle");
  dur_back_a: assert property (wrDur ##1 rdDur |=>
    regRdataFf == $past(regReq.wdata, 2)) else $error("duration readback");
  no_sleep_a: assert property (!aslpFf && modeFf != MODE_SLEEP |=>
    modeFf != MODE_SLEEP) else $error("sleep with auto sleep off");
  sleep_rate_a: assert property (modeFf == MODE_SLEEP |->
    outputSampleRateFf == {1'b1, slpFf}) else $error("sleep rate wrong");
  wake_rate_a: assert property (modeFf == MODE_WAKE |->
    outputSampleRateFf == wakeFf) else $error("wake rate wrong");
  sw_event_a: assert property (sleepWakeEventFf == ($past(ienFf)
    && $past(modeFf) != MODE_STANDBY && modeFf != MODE_STANDBY
    && modeFf != $past(modeFf))) else $error("sleep wake event wrong");
  event_wake_a: assert property (modeFf == MODE_SLEEP && wake && ce
    && actFf && !regReq.wr |=> modeFf == MODE_WAKE)
    else $error("no wake on event");
  stay_asleep_a: assert property (modeFf == MODE_SLEEP && !wake
    && aslpFf && actFf && ce && !regReq.wr |=> modeFf == MODE_SLEEP)
    else $error("woke without source");
  idle_min_a: assert property (modeFf == MODE_WAKE
    && idleFf < minIdle |=> modeFf != MODE_SLEEP) else $error("early sleep");
  enables_a: assert property (functionEnableFf == enFf)
    else $error("function enables wrong");
  sleep_c: cover property (modeFf == MODE_WAKE ##1 modeFf == MODE_SLEEP);
  wake_c: cover property (modeFf == MODE_SLEEP ##1 modeFf == MODE_WAKE);
  pulse_c: cover property (sleepWakeEventFf);
endmodule : awsc_monitor

bind auto_wake_sleep_control awsc_monitor #(.BASE_CYCLES(BASE_CYCLES)) u_mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .regReq(regReq),
  .regRdataFf(regRdataFf), .detectEvents(detectEvents),
  .outputSampleRateFf(outputSampleRateFf), .sampleTickFf(sampleTickFf),
  .functionEnableFf(functionEnableFf), .modeFf(modeFf),
  .sleepWakeEventFf(sleepWakeEventFf));
